// File: logic/lod_config_regs.sv
// lead-off detection configuration registers with status qualification and excitation steering
`timescale 1ns/100ps
`include "lod_map.svh"
module lod_config_regs #(
  parameter int CHANNELS = `LOD_MAX_CHANNELS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [7:0] leadOffPosRaw,
  input wire logic [7:0] leadOffNegRaw,
  output logic [7:0] posMonitorEnable,
  output logic [7:0] negMonitorEnable,
  output lod_pkg::lod_excite_t excite,
  output logic [7:0] leadOffPosStatus,
  output logic [7:0] leadOffNegStatus,
  output logic [7:0] leadOffPosValid,
  output logic [7:0] leadOffNegValid
);

  lod_pkg::lod_byte_t posEnable_reg;
  lod_pkg::lod_byte_t negEnable_reg;
  lod_pkg::lod_byte_t polarityFlip_reg;
  lod_pkg::lod_byte_t regRdata_next;
  lod_pkg::lod_bus_req_t req;
  lod_pkg::lod_byte_t chanMask;
  lod_pkg::lod_excite_t excite_next;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWrite, rd: regRead};

  // ones for channels that exist on this variant
  function automatic lod_pkg::lod_byte_t presentMask(input int n);
    lod_pkg::lod_byte_t m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign chanMask = presentMask(CHANNELS);

  // absent-channel bits are stored as written but drive nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      posEnable_reg <= `LOD_RST_POS_ENABLE;
    end else if (clkEnable && req.wr && hit(req.addr, `LOD_OFF_POS_ENABLE)) begin
      posEnable_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      negEnable_reg <= `LOD_RST_NEG_ENABLE;
    end else if (clkEnable && req.wr && hit(req.addr, `LOD_OFF_NEG_ENABLE)) begin
      negEnable_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      polarityFlip_reg <= `LOD_RST_POLARITY_FLIP;
    end else if (clkEnable && req.wr && hit(req.addr, `LOD_OFF_POLARITY_FLIP)) begin
      polarityFlip_reg <= req.wdata;
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    if (hit(req.addr, `LOD_OFF_POS_ENABLE)) begin
      regRdata_next = posEnable_reg;
    end else if (hit(req.addr, `LOD_OFF_NEG_ENABLE)) begin
      regRdata_next = negEnable_reg;
    end else if (hit(req.addr, `LOD_OFF_POLARITY_FLIP)) begin
      regRdata_next = polarityFlip_reg;
    end else begin
      regRdata_next = 8'h00;
    end
  end

  // read data stands from the strobe's enabled edge until the next enabled edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdata <= 8'h00;
    end else if (clkEnable) begin
      regRdata <= req.rd ? regRdata_next : 8'h00;
    end
  end

  // excitation only where a side is monitored on a present channel
  always_comb begin
    excite_next.posPullUp = posEnable_reg & chanMask & ~polarityFlip_reg;
    excite_next.posPullDown = posEnable_reg & chanMask & polarityFlip_reg;
    excite_next.negPullDown = negEnable_reg & chanMask & ~polarityFlip_reg;
    excite_next.negPullUp = negEnable_reg & chanMask & polarityFlip_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      excite <= '0;
    end else if (clkEnable) begin
      excite <= excite_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      posMonitorEnable <= 8'h00;
      negMonitorEnable <= 8'h00;
    end else if (clkEnable) begin
      posMonitorEnable <= posEnable_reg & chanMask;
      negMonitorEnable <= negEnable_reg & chanMask;
    end
  end

  // status of disabled inputs is forced to zero so nothing downstream trusts it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      leadOffPosStatus <= 8'h00;
      leadOffNegStatus <= 8'h00;
    end else if (clkEnable) begin
      leadOffPosStatus <= leadOffPosRaw & posEnable_reg & chanMask;
      leadOffNegStatus <= leadOffNegRaw & negEnable_reg & chanMask;
    end
  end

  // valid vectors tell downstream which status bits may be trusted
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      leadOffPosValid <= 8'h00;
      leadOffNegValid <= 8'h00;
    end else if (clkEnable) begin
      leadOffPosValid <= posEnable_reg & chanMask;
      leadOffNegValid <= negEnable_reg & chanMask;
    end
  end

  AST_POS_WRITE_READBACK: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_POS_ENABLE ##1 clkEnable && regRead
      && regAddr == `LOD_OFF_POS_ENABLE && !regWrite |=> regRdata == $past(regWdata, 2))
    else $error("positive enable readback mismatch");

  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
    clkEnable && !regRead |=> regRdata == 8'h00)
    else $error("read data outside its cycle");

  AST_POS_STATUS_MASK: assert property (@(posedge clk) disable iff (reset)
    (leadOffPosStatus & ~leadOffPosValid) == 8'h00)
    else $error("positive status on unmonitored input");

  AST_NEG_STATUS_MASK: assert property (@(posedge clk) disable iff (reset)
    (leadOffNegStatus & ~leadOffNegValid) == 8'h00)
    else $error("negative status on unmonitored input");

  AST_NO_FLIP: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> (excite.posPullDown & ~$past(polarityFlip_reg)) == 8'h00
      && excite.posPullUp == ($past(posEnable_reg) & chanMask & ~$past(polarityFlip_reg)))
    else $error("unflipped excitation wrong");

  AST_FLIP: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> excite.negPullUp == ($past(negEnable_reg) & chanMask & $past(polarityFlip_reg)))
    else $error("flipped excitation wrong");

  AST_ABSENT_CHANNELS: assert property (@(posedge clk) disable iff (reset)
    ((posMonitorEnable | negMonitorEnable) & ~chanMask) == 8'h00)
    else $error("absent channel monitored");

  AST_NEG_ENABLE_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_NEG_ENABLE ##1 clkEnable
      |=> negMonitorEnable == ($past(regWdata, 2) & chanMask))
    else $error("negative enable not applied");

  AST_POS_ENABLE_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_POS_ENABLE ##1 clkEnable
      |=> posMonitorEnable == ($past(regWdata, 2) & chanMask))
    else $error("positive enable not applied");

  AST_NEG_WRITE_READBACK: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_NEG_ENABLE ##1 clkEnable && regRead
      && regAddr == `LOD_OFF_NEG_ENABLE && !regWrite |=> regRdata == $past(regWdata, 2))
    else $error("negative enable readback mismatch");

  AST_FLIP_WRITE_READBACK: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_POLARITY_FLIP ##1 clkEnable && regRead
      && regAddr == `LOD_OFF_POLARITY_FLIP && !regWrite |=> regRdata == $past(regWdata, 2))
    else $error("polarity flip readback mismatch");

  AST_UNMAPPED_READ_ZERO: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regRead && regAddr != `LOD_OFF_POS_ENABLE && regAddr != `LOD_OFF_NEG_ENABLE
      && regAddr != `LOD_OFF_POLARITY_FLIP |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");

  AST_POS_WRITE_LANDS: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_POS_ENABLE
      |=> posEnable_reg == $past(regWdata))
    else $error("positive enable write lost");

  AST_NEG_WRITE_LANDS: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_NEG_ENABLE
      |=> negEnable_reg == $past(regWdata))
    else $error("negative enable write lost");

  AST_FLIP_WRITE_LANDS: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr == `LOD_OFF_POLARITY_FLIP
      |=> polarityFlip_reg == $past(regWdata))
    else $error("polarity flip write lost");

  AST_UNMAPPED_WRITE_IGNORED: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regWrite && regAddr != `LOD_OFF_POS_ENABLE && regAddr != `LOD_OFF_NEG_ENABLE
      && regAddr != `LOD_OFF_POLARITY_FLIP
      |=> $stable(posEnable_reg) && $stable(negEnable_reg) && $stable(polarityFlip_reg))
    else $error("unmapped write changed a register");

  AST_FROZEN_REGS: assert property (@(posedge clk) disable iff (reset)
    !clkEnable |=> $stable(posEnable_reg) && $stable(negEnable_reg) && $stable(polarityFlip_reg))
    else $error("register changed while frozen");

  AST_FROZEN_OUTPUTS: assert property (@(posedge clk) disable iff (reset)
    !clkEnable |=> $stable(regRdata) && $stable(excite) && $stable(posMonitorEnable)
      && $stable(negMonitorEnable) && $stable(leadOffPosStatus) && $stable(leadOffNegStatus))
    else $error("output changed while frozen");

  AST_RESET_CLEAR: assert property (@(posedge clk)
    reset ##1 reset |-> posEnable_reg == 8'h00 && negEnable_reg == 8'h00
      && polarityFlip_reg == 8'h00 && regRdata == 8'h00)
    else $error("registers not cleared by reset");

  AST_RESET_OUTPUTS_CLEAR: assert property (@(posedge clk)
    reset ##1 reset |-> excite == '0 && posMonitorEnable == 8'h00 && negMonitorEnable == 8'h00
      && leadOffPosValid == 8'h00 && leadOffNegValid == 8'h00)
    else $error("derived outputs not cleared by reset");

  AST_NO_FLIP_NEG: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> excite.negPullDown == ($past(negEnable_reg) & chanMask & ~$past(polarityFlip_reg)))
    else $error("unflipped negative excitation wrong");

  AST_FLIP_POS: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> excite.posPullDown == ($past(posEnable_reg) & chanMask & $past(polarityFlip_reg)))
    else $error("flipped positive excitation wrong");

  AST_POS_PULL_EXCLUSIVE: assert property (@(posedge clk) disable iff (reset)
    (excite.posPullUp & excite.posPullDown) == 8'h00)
    else $error("positive input pulled both ways");

  AST_NEG_PULL_EXCLUSIVE: assert property (@(posedge clk) disable iff (reset)
    (excite.negPullUp & excite.negPullDown) == 8'h00)
    else $error("negative input pulled both ways");

  AST_POS_EXCITE_MONITORED: assert property (@(posedge clk) disable iff (reset)
    ((excite.posPullUp | excite.posPullDown) & ~posMonitorEnable) == 8'h00)
    else $error("excitation on unmonitored positive input");

  AST_NEG_EXCITE_MONITORED: assert property (@(posedge clk) disable iff (reset)
    ((excite.negPullUp | excite.negPullDown) & ~negMonitorEnable) == 8'h00)
    else $error("excitation on unmonitored negative input");

  AST_POS_VALID_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> leadOffPosValid == ($past(posEnable_reg) & chanMask))
    else $error("positive valid vector wrong");

  AST_NEG_VALID_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> leadOffNegValid == ($past(negEnable_reg) & chanMask))
    else $error("negative valid vector wrong");

  AST_POS_STATUS_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> leadOffPosStatus == ($past(leadOffPosRaw) & $past(posEnable_reg) & chanMask))
    else $error("positive status wrong");

  AST_NEG_STATUS_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> leadOffNegStatus == ($past(leadOffNegRaw) & $past(negEnable_reg) & chanMask))
    else $error("negative status wrong");

  AST_ABSENT_STATUS: assert property (@(posedge clk) disable iff (reset)
    ((leadOffPosStatus | leadOffNegStatus | leadOffPosValid | leadOffNegValid) & ~chanMask) == 8'h00)
    else $error("absent channel status shown");

  AST_ABSENT_EXCITE: assert property (@(posedge clk) disable iff (reset)
    ((excite.posPullUp | excite.posPullDown | excite.negPullUp | excite.negPullDown) & ~chanMask) == 8'h00)
    else $error("absent channel excited");

  AST_READ_POS_DATA: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regRead && regAddr == `LOD_OFF_POS_ENABLE
      |=> regRdata == $past(posEnable_reg))
    else $error("positive enable read wrong");

  AST_READ_NEG_DATA: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regRead && regAddr == `LOD_OFF_NEG_ENABLE
      |=> regRdata == $past(negEnable_reg))
    else $error("negative enable read wrong");

  AST_READ_FLIP_DATA: assert property (@(posedge clk) disable iff (reset)
    clkEnable && regRead && regAddr == `LOD_OFF_POLARITY_FLIP
      |=> regRdata == $past(polarityFlip_reg))
    else $error("polarity flip read wrong");

endmodule

// File: logic/lod_map.svh
// register offsets, reset values and channel geometry of the lead-off configuration bank
`ifndef LOD_MAP_SVH
`define LOD_MAP_SVH
`define LOD_ADDR_W 8
`define LOD_OFF_POS_ENABLE 8'h0f
`define LOD_OFF_NEG_ENABLE 8'h10
`define LOD_OFF_POLARITY_FLIP 8'h11
`define LOD_RST_POS_ENABLE 8'h00
`define LOD_RST_NEG_ENABLE 8'h00
`define LOD_RST_POLARITY_FLIP 8'h00
`define LOD_MAX_CHANNELS 8
`endif

// File: logic/lod_pkg.sv
// types shared by the lead-off configuration bank
package lod_pkg;
  typedef logic [7:0] lod_byte_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lod_bus_req_t;
  typedef struct packed {
    logic [7:0] posPullUp;
    logic [7:0] posPullDown;
    logic [7:0] negPullUp;
    logic [7:0] negPullDown;
  } lod_excite_t;
endpackage

// File: test/lod_config_regs_test.sv
// self-checking bench for the lead-off configuration bank
`timescale 1ns/100ps
`include "lod_map.svh"
module lod_config_regs_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clkEnable = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic [7:0] leadOffPosRaw = 8'h00;
  logic [7:0] leadOffNegRaw = 8'h00;
  logic [7:0] posMonitorEnable, negMonitorEnable, leadOffPosStatus, leadOffNegStatus, leadOffPosValid, leadOffNegValid;
  lod_pkg::lod_excite_t excite;
  int failures = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  // six-channel variant, so bits 7:6 must stay out of every derived output
  lod_config_regs #(.CHANNELS(6)) dut (.clk(clk), .reset(reset), .clkEnable(clkEnable), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .leadOffPosRaw(leadOffPosRaw), .leadOffNegRaw(leadOffNegRaw), .posMonitorEnable(posMonitorEnable),
    .negMonitorEnable(negMonitorEnable), .excite(excite), .leadOffPosStatus(leadOffPosStatus),
    .leadOffNegStatus(leadOffNegStatus), .leadOffPosValid(leadOffPosValid), .leadOffNegValid(leadOffNegValid));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk("regRdata", exp, regRdata);
  endtask
  // write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk("regRdata", d, regRdata);
  endtask
  // derived outputs trail the register by one edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`LOD_OFF_POS_ENABLE, `LOD_RST_POS_ENABLE);
    rd(`LOD_OFF_NEG_ENABLE, `LOD_RST_NEG_ENABLE);
    rd(`LOD_OFF_POLARITY_FLIP, `LOD_RST_POLARITY_FLIP);
    chk("posMonitorEnable", 8'h00, posMonitorEnable);
    wr_rd(`LOD_OFF_POS_ENABLE, 8'h12);
    wr_rd(`LOD_OFF_NEG_ENABLE, 8'h21);
    wr_rd(`LOD_OFF_POLARITY_FLIP, 8'h33);
    wr(`LOD_OFF_POS_ENABLE, 8'h25);
    rd(`LOD_OFF_POS_ENABLE, 8'h25);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h00);
    wr(`LOD_OFF_NEG_ENABLE, 8'h3f);
    wr(`LOD_OFF_POLARITY_FLIP, 8'h3c);
    rd(`LOD_OFF_NEG_ENABLE, 8'h3f);
    rd(`LOD_OFF_POLARITY_FLIP, 8'h3c);
    @(posedge clk);
    leadOffPosRaw <= 8'hff;
    leadOffNegRaw <= 8'h5a;
    settle;
    chk("posMonitorEnable", 8'h25, posMonitorEnable);
    chk("negMonitorEnable", 8'h3f, negMonitorEnable);
    chk("leadOffPosValid", 8'h25, leadOffPosValid);
    chk("leadOffNegValid", 8'h3f, leadOffNegValid);
    chk("leadOffPosStatus", 8'h25, leadOffPosStatus);
    chk("leadOffNegStatus", 8'h1a, leadOffNegStatus);
    chk("posPullUp", 8'h01, excite.posPullUp);
    chk("posPullDown", 8'h24, excite.posPullDown);
    chk("negPullUp", 8'h3c, excite.negPullUp);
    chk("negPullDown", 8'h03, excite.negPullDown);
    // a frozen cycle must not take the write
    @(posedge clk);
    clkEnable <= 1'b0;
    wr(`LOD_OFF_POS_ENABLE, 8'h00);
    clkEnable <= 1'b1;
    rd(`LOD_OFF_POS_ENABLE, 8'h25);
    wr(`LOD_OFF_POS_ENABLE, 8'h00);
    settle;
    chk("leadOffPosStatus", 8'h00, leadOffPosStatus);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`LOD_OFF_POLARITY_FLIP, 8'h00);
    rd(`LOD_OFF_NEG_ENABLE, 8'h00);
    chk("leadOffNegValid", 8'h00, leadOffNegValid);
    close_out;
  end
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule
